/* File: hw/crsm_top.v */
// RUN/STOP mode controller: scan sequencer, tool gating and memory policy
`timescale 1ns/1ps
`default_nettype none
`include "crsm_defines.vh"

// Operation
// - In STOP no part of the user program is started.
// - In STOP accept table and program downloads, config init, checking, forcing.
// - In RUN the user program is started every scan.
// - In RUN reject module-table downloads and configuration initialisation.
// - In STOP outputs go off unless the bit holds its last value.
// - In RUN outputs follow only the program's output image.
// - In STOP neither program memory area is written.
// - In STOP no loop task is launched.
// - In STOP no interrupt task is launched.
// - In RUN a loop task never yet run reports HALT.
// - In RUN a task runs when active or after the enable instruction.
// - In RUN a task is skipped when inactive or after the disable instruction.
// - In RUN an interrupt task runs when its condition is met.
// - STOP to RUN clears or keeps the non-latched area per configuration.
// - Latched area always kept; non-latched kept going RUN to STOP.
// - Inputs refresh before program execution, outputs after, in one loop.
module crsm_top
(
  input  wire                      clock,
  input  wire                      arst_n,
  input  wire                      run_request,
  input  wire                      clear_nonlatched_cfg,
  input  wire                      prog_exec_done,
  input  wire                      tool_op_valid,
  input  wire [`CRSM_OP_W-1:0]     tool_op_code,
  input  wire [`CRSM_NOUT-1:0]     force_on_mask,
  input  wire [`CRSM_NOUT-1:0]     force_off_mask,
  input  wire                      mem_wr_req,
  input  wire                      mem_wr_latched,
  input  wire [`CRSM_NTASK-1:0]    task_active_cfg,
  input  wire                      task_enable_instr,
  input  wire                      task_disable_instr,
  input  wire [`CRSM_TIDX_W-1:0]   task_idx,
  input  wire [`CRSM_NTASK-1:0]    int_cond,
  input  wire [`CRSM_NOUT-1:0]     prog_out_data,
  input  wire [`CRSM_NOUT-1:0]     hold_last_cfg,
  output wire                      run_mode,
  output wire                      in_refresh,
  output wire                      out_refresh,
  output reg                       prog_exec_start,
  output reg                       tool_op_accept,
  output reg                       tool_op_reject,
  output reg  [`CRSM_NOUT-1:0]     force_image,
  output wire                      nonlatched_wr_en,
  output wire                      latched_wr_en,
  output reg                       nonlatched_clear,
  output wire [`CRSM_NTASK-1:0]    loop_task_run,
  output wire [`CRSM_NTASK-1:0]    int_task_run,
  output wire [`CRSM_NTASK-1:0]    task_halted,
  output wire [`CRSM_NOUT-1:0]     ext_out
);

  reg                      mode_reg;
  reg  [`CRSM_ST_W-1:0]    state_reg;
  reg  [`CRSM_ST_W-1:0]    state_next;
  reg                      exec_busy_reg;
  reg                      enter_run_reg;
  wire                     scan_start;
  wire                     op_ok;

  assign run_mode    = mode_reg;
  // Input refresh leads, output refresh trails the pass
  assign in_refresh  = (state_reg == `CRSM_ST_IN);
  assign out_refresh = (state_reg == `CRSM_ST_OUT);
  assign scan_start  = in_refresh;

  // Memory writes only while the program is executing in RUN
  assign nonlatched_wr_en = mode_reg && exec_busy_reg && mem_wr_req && !mem_wr_latched;
  assign latched_wr_en    = mode_reg && exec_busy_reg && mem_wr_req && mem_wr_latched;

  // Scan sequencer; STOP still refreshes I/O but skips execution
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `CRSM_ST_IN:
        state_next = `CRSM_ST_EXEC;
      `CRSM_ST_EXEC:
      begin
        if (!mode_reg)
          state_next = `CRSM_ST_OUT;
        else if (exec_busy_reg && prog_exec_done)
          state_next = `CRSM_ST_OUT;
      end
      `CRSM_ST_OUT:
        state_next = `CRSM_ST_BOUND;
      `CRSM_ST_BOUND:
        state_next = `CRSM_ST_IN;
      default:
        state_next = `CRSM_ST_IN;
    endcase
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg        <= `CRSM_ST_IN;
      mode_reg         <= `CRSM_MODE_STOP;
      exec_busy_reg    <= 1'b0;
      prog_exec_start  <= 1'b0;
      enter_run_reg    <= 1'b0;
      nonlatched_clear <= 1'b0;
    end
    else
    begin
      state_reg        <= state_next;
      prog_exec_start  <= 1'b0;
      enter_run_reg    <= 1'b0;
      nonlatched_clear <= 1'b0;
      // Start pulse issued once per pass, RUN only
      if (state_reg == `CRSM_ST_EXEC && mode_reg && !exec_busy_reg)
      begin
        prog_exec_start <= 1'b1;
        exec_busy_reg   <= 1'b1;
      end
      else if (exec_busy_reg && prog_exec_done)
        exec_busy_reg <= 1'b0;
      // Mode moves only between loops so a pass never sees it change
      if (state_reg == `CRSM_ST_BOUND && mode_reg != run_request)
      begin
        mode_reg <= run_request;
        if (run_request)
        begin
          enter_run_reg    <= 1'b1;
          nonlatched_clear <= clear_nonlatched_cfg;
        end
      end
    end
  end

  // Tool operations: configuration-changing ones are STOP-only
  assign op_ok = !mode_reg ||
                 (tool_op_code == `CRSM_OP_PROGDL) ||
                 (tool_op_code == `CRSM_OP_PROGCHK) ||
                 (tool_op_code == `CRSM_OP_FORCE);

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tool_op_accept <= 1'b0;
      tool_op_reject <= 1'b0;
      force_image    <= {`CRSM_NOUT{1'b0}};
    end
    else
    begin
      tool_op_accept <= 1'b0;
      tool_op_reject <= 1'b0;
      if (tool_op_valid)
      begin
        if (tool_op_code > `CRSM_OP_FORCE)
          tool_op_reject <= 1'b1;
        else if (mode_reg && !op_ok)
          tool_op_reject <= 1'b1;
        else
        begin
          tool_op_accept <= 1'b1;
          if (tool_op_code == `CRSM_OP_FORCE)
            force_image <= (force_image | force_on_mask) & ~force_off_mask;
        end
      end
    end
  end

  crsm_task_sched u_sched
  (
    .clock              (clock),
    .arst_n             (arst_n),
    .run_mode           (mode_reg),
    .enter_run          (enter_run_reg),
    .scan_start         (scan_start),
    .task_active_cfg    (task_active_cfg),
    .task_enable_instr  (task_enable_instr),
    .task_disable_instr (task_disable_instr),
    .task_idx           (task_idx),
    .int_cond           (int_cond),
    .loop_task_run      (loop_task_run),
    .int_task_run       (int_task_run),
    .task_halted        (task_halted)
  );

  crsm_out_gate u_out
  (
    .clock         (clock),
    .arst_n        (arst_n),
    .run_mode      (mode_reg),
    .out_refresh   (out_refresh),
    .prog_out_data (prog_out_data),
    .hold_last_cfg (hold_last_cfg),
    .ext_out       (ext_out)
  );

endmodule

`default_nettype wire

/* File: pkg/crsm_defines.vh */
// Constants for the RUN/STOP mode controller
`ifndef CRSM_DEFINES_VH
`define CRSM_DEFINES_VH

`define CRSM_MODE_STOP   1'b0
`define CRSM_MODE_RUN    1'b1

`define CRSM_NTASK       8
`define CRSM_TIDX_W      3
`define CRSM_NOUT        16

`define CRSM_OP_W        3
`define CRSM_OP_MODTAB   3'h0
`define CRSM_OP_CFGINIT  3'h1
`define CRSM_OP_PROGDL   3'h2
`define CRSM_OP_PROGCHK  3'h3
`define CRSM_OP_FORCE    3'h4

`define CRSM_ST_W        2
`define CRSM_ST_IN       2'h0
`define CRSM_ST_EXEC     2'h1
`define CRSM_ST_OUT      2'h2
`define CRSM_ST_BOUND    2'h3

`endif

/* File: hw/crsm_task_sched.v */
// Loop and interrupt task scheduler for the mode controller
`timescale 1ns/1ps
`default_nettype none
`include "crsm_defines.vh"

module crsm_task_sched
(
  input  wire                      clock,
  input  wire                      arst_n,
  input  wire                      run_mode,
  input  wire                      enter_run,
  input  wire                      scan_start,
  input  wire [`CRSM_NTASK-1:0]    task_active_cfg,
  input  wire                      task_enable_instr,
  input  wire                      task_disable_instr,
  input  wire [`CRSM_TIDX_W-1:0]   task_idx,
  input  wire [`CRSM_NTASK-1:0]    int_cond,
  output reg  [`CRSM_NTASK-1:0]    loop_task_run,
  output reg  [`CRSM_NTASK-1:0]    int_task_run,
  output wire [`CRSM_NTASK-1:0]    task_halted
);

  reg [`CRSM_NTASK-1:0] enabled_reg;
  reg [`CRSM_NTASK-1:0] ran_reg;

  // Never-run tasks report HALT; the entry cycle forces all, ran_reg still stale there
  assign task_halted = ~ran_reg | {`CRSM_NTASK{enter_run}};

  genvar g;
  generate
    for (g = 0; g < `CRSM_NTASK; g = g + 1)
    begin : g_task
      wire launch;
      // First pass after entry uses the new active set, not the old enables
      assign launch = run_mode && scan_start && (enter_run ? task_active_cfg[g] : enabled_reg[g]);
      always @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
        begin
          enabled_reg[g]   <= 1'b0;
          ran_reg[g]       <= 1'b0;
          loop_task_run[g] <= 1'b0;
          int_task_run[g]  <= 1'b0;
        end
        else
        begin
          if (enter_run)
          begin
            enabled_reg[g] <= task_active_cfg[g];
            ran_reg[g]     <= 1'b0;
          end
          else if (run_mode && task_enable_instr && task_idx == g)
            enabled_reg[g] <= 1'b1;
          else if (run_mode && task_disable_instr && task_idx == g)
            enabled_reg[g] <= 1'b0;
          // Gated on mode so nothing launches in STOP
          loop_task_run[g] <= launch;
          int_task_run[g]  <= run_mode && int_cond[g];
          if (launch)
            ran_reg[g] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: hw/crsm_out_gate.v */
// External output image with STOP-mode off and hold-last behaviour
`timescale 1ns/1ps
`default_nettype none
`include "crsm_defines.vh"

module crsm_out_gate
(
  input  wire                      clock,
  input  wire                      arst_n,
  input  wire                      run_mode,
  input  wire                      out_refresh,
  input  wire [`CRSM_NOUT-1:0]     prog_out_data,
  input  wire [`CRSM_NOUT-1:0]     hold_last_cfg,
  output reg  [`CRSM_NOUT-1:0]     ext_out
);

  genvar g;
  generate
    for (g = 0; g < `CRSM_NOUT; g = g + 1)
    begin : g_out
      always @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
          ext_out[g] <= 1'b0;
        else if (out_refresh)
        begin
          if (run_mode)
            ext_out[g] <= prog_out_data[g];
          else if (!hold_last_cfg[g])
            ext_out[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: dv/crsm_checker.sv */
// Port assertions for the RUN/STOP mode controller
`timescale 1ns/1ps
`default_nettype none
module crsm_checker
(
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        clear_nonlatched_cfg,
  input wire logic        tool_op_valid,
  input wire logic [2:0]  tool_op_code,
  input wire logic [7:0]  int_cond,
  input wire logic [15:0] prog_out_data,
  input wire logic [15:0] hold_last_cfg,
  input wire logic        run_mode,
  input wire logic        in_refresh,
  input wire logic        out_refresh,
  input wire logic        prog_exec_start,
  input wire logic        tool_op_accept,
  input wire logic        tool_op_reject,
  input wire logic        nonlatched_wr_en,
  input wire logic        latched_wr_en,
  input wire logic        nonlatched_clear,
  input wire logic [7:0]  loop_task_run,
  input wire logic [7:0]  int_task_run,
  input wire logic [15:0] ext_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Scan tail: output refresh, boundary, then input refresh
  sequence s_tail; out_refresh ##1 !in_refresh ##1 in_refresh; endsequence
  property p_loop; out_refresh |-> s_tail; endproperty
  a_loop: assert property (p_loop) else $error("scan loop order broken");
  property p_run_exec; run_mode && in_refresh |-> ##2 prog_exec_start; endproperty
  a_run_exec: assert property (p_run_exec) else $error("program not started in run");
  property p_stop_exec; !run_mode |-> !prog_exec_start; endproperty
  a_stop_exec: assert property (p_stop_exec) else $error("program started in stop");
  property p_stop_loop; !run_mode |-> loop_task_run == 8'h00; endproperty
  a_stop_loop: assert property (p_stop_loop) else $error("loop task in stop");
  // Interrupt launch follows the condition one cycle later, run only
  property p_int; int_task_run == ($past(run_mode) ? $past(int_cond) : 8'h00); endproperty
  a_int: assert property (p_int) else $error("interrupt launch wrong");
  property p_rej; tool_op_valid && run_mode && tool_op_code < 3'h2 |=> tool_op_reject; endproperty
  a_rej: assert property (p_rej) else $error("table or init op taken in run");
  property p_acc; tool_op_valid && !run_mode && tool_op_code < 3'h5 |=> tool_op_accept && !tool_op_reject;
  endproperty
  a_acc: assert property (p_acc) else $error("op refused in stop");
  property p_mem; !run_mode |-> !nonlatched_wr_en && !latched_wr_en; endproperty
  a_mem: assert property (p_mem) else $error("memory written in stop");
  property p_mode; run_mode != $past(run_mode) |-> in_refresh && $past(out_refresh, 2); endproperty
  a_mode: assert property (p_mode) else $error("mode changed off boundary");
  property p_clr; nonlatched_clear == ($rose(run_mode) && $past(clear_nonlatched_cfg)); endproperty
  a_clr: assert property (p_clr) else $error("non-latched clear wrong");
  property p_out;
    $past(out_refresh) |-> ext_out == ($past(run_mode) ? $past(prog_out_data) : $past(ext_out) & $past(hold_last_cfg));
  endproperty
  a_out: assert property (p_out) else $error("external output wrong");
endmodule
bind crsm_top crsm_checker chk_i (.*);
`default_nettype wire

/* File: dv/crsm_prog_model.sv */
// User program model: answers a pass start after lat cycles
`timescale 1ns/1ps
`default_nettype none
module crsm_prog_model
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       prog_exec_start,
  input  wire logic [3:0] lat,
  output var  logic       prog_exec_done
);
  logic       busy_reg;
  logic [3:0] cnt_reg;
  // Zero latency answers in the start cycle itself
  assign prog_exec_done = busy_reg ? (cnt_reg == lat) : (prog_exec_start && lat == 4'h0);
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end
    else
    begin
      busy_reg <= !prog_exec_done && (busy_reg || prog_exec_start);
      cnt_reg <= busy_reg ? cnt_reg + 4'h1 : 4'h1;
    end
endmodule
`default_nettype wire

/* File: dv/crsm_top_tb_top.sv */
// Self-checking bench for the RUN/STOP mode controller
`timescale 1ns/1ps
`default_nettype none
module crsm_top_tb_top;
  logic             clock = 1'b0, arst_n = 1'b0, run_request = 1'b0, clear_nonlatched_cfg = 1'b1;
  logic             tool_op_valid = 1'b0, mem_wr_req = 1'b1, mem_wr_latched = 1'b0;
  logic             task_enable_instr = 1'b0, task_disable_instr = 1'b0;
  logic [2:0]       tool_op_code = 3'h0, task_idx = 3'h0;
  logic [3:0]       lat = 4'h3;
  logic [7:0]       task_active_cfg = 8'h05, int_cond = 8'h81;
  logic [15:0]      force_on_mask = 16'h00F0, force_off_mask = 16'h0030;
  logic [15:0]      prog_out_data = 16'hA5C3, hold_last_cfg = 16'h00FF;
  wire logic        prog_exec_done, run_mode, in_refresh, out_refresh, prog_exec_start;
  wire logic        tool_op_accept, tool_op_reject, nonlatched_wr_en, latched_wr_en, nonlatched_clear;
  wire logic [7:0]  loop_task_run, int_task_run, task_halted;
  wire logic [15:0] force_image, ext_out;
  integer           err_total = 0, checked = 0;
  always #5 clock = ~clock;
  crsm_top DUT (.*);
  crsm_prog_model prog_model (.clock(clock), .arst_n(arst_n), .prog_exec_start(prog_exec_start),
    .lat(lat), .prog_exec_done(prog_exec_done));
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked = checked + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task step;
    @(posedge clock) #1;
  endtask
  task test_done;
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Bounded wait: 1 for output refresh, 0 for input refresh
  task wait_on(input logic sel);
    for (int n = 0; n < 40 && (sel ? out_refresh : in_refresh) !== 1'b1; n++)
      step;
  endtask
  task tool(input logic [2:0] c, input logic acc);
    @(posedge clock);
    tool_op_valid <= 1'b1;
    tool_op_code <= c;
    @(posedge clock);
    tool_op_valid <= 1'b0;
    #1;
    chk("accept", acc, tool_op_accept);
    chk("reject", !acc, tool_op_reject);
  endtask
  task t_mode(input logic m, input logic clr, input logic [7:0] act);
    @(posedge clock);
    run_request <= m;
    clear_nonlatched_cfg <= clr;
    task_active_cfg <= act;
    for (int n = 0; n < 40 && run_mode !== m; n++)
      step;
    chk("mode", m, run_mode);
    chk("clear", m & clr, nonlatched_clear);
    if (m)
    begin
      chk("halt", 8'hFF, task_halted);
      step;
      chk("loop", act, loop_task_run);
      step;
      chk("halt2", act ^ 8'hFF, task_halted);
    end
    chk("wr", m ? (mem_wr_latched ? 16'h0002 : 16'h0001) : 16'h0000, {latched_wr_en, nonlatched_wr_en});
  endtask
  task t_tasks;
    @(posedge clock);
    task_disable_instr <= 1'b1;
    task_idx <= 3'h0;
    @(posedge clock);
    task_disable_instr <= 1'b0;
    task_enable_instr <= 1'b1;
    task_idx <= 3'h1;
    @(posedge clock);
    task_enable_instr <= 1'b0;
    wait_on(1'b0);
    step;
    chk("instr", 16'h0006, loop_task_run);
  endtask
  task t_io(input logic [15:0] exp, input logic [7:0] iexp);
    @(posedge clock);
    int_cond <= 8'h3C;
    prog_out_data <= 16'h5A96;
    step;
    chk("int", iexp, int_task_run);
    wait_on(1'b1);
    step;
    chk("out", exp, ext_out);
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    step;
    chk("rst", 8'hFF, task_halted);
    for (int c = 0; c < 6; c++)
      tool(c[2:0], c < 5);
    chk("force", 16'h00C0, force_image);
    t_mode(1'b1, 1'b1, 8'h05);
    t_tasks;
    t_io(16'h5A96, 8'h3C);
    t_mode(1'b0, 1'b0, 8'h00);
    t_io(16'h0096, 8'h00);
    @(posedge clock);
    lat <= 4'h0;
    mem_wr_latched <= 1'b1;
    t_mode(1'b1, 1'b0, 8'h81);
    for (int c = 0; c < 5; c++)
      tool(c[2:0], c > 1);
    test_done;
  end
  // Hang guard, far beyond the seventy or so cycles the run needs
  initial
  begin
    #20000;
    err_total = err_total + 1;
    test_done;
  end
endmodule
`default_nettype wire
